// [design/ards_pkg.sv]
// constants for the converter result and voltage detect select block
package ards_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int VAL_W = 10;
  localparam int CH_W = 3;
  localparam int IDX_W = 4;
  localparam int CONV0_CH = 6;
  localparam int CONV1_CH = 8;
  localparam int MEM_DEPTH = 16;
  localparam int CONV1_BASE = 8;
  localparam int RES_NUM = 14;
  localparam int IRQ_W = 4;

  // ---------------------------------------------------------------
  // result register offsets, as printed
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RES_ADDR [0:RES_NUM-1] = '{
    32'h0ffff210, 32'hfffff212, 32'hfffff214, 32'h0ffff216,
    32'hfffff218, 32'hfffff21a,
    32'h0ffff250, 32'h0ffff252, 32'h0ffff254, 32'h0ffff256,
    32'h0ffff258, 32'h0ffff25a, 32'h0ffff25c, 32'h0ffff25e
  };
  // memory slot of each entry of the table above
  localparam logic [IDX_W-1:0] RES_SLOT [0:RES_NUM-1] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf
  };
  localparam logic [DATA_W-1:0] RES_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // voltage detect mode registers
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DETM0_ADDR = 32'hfffff204;
  localparam logic [ADDR_W-1:0] DETM1_ADDR = 32'hfffff244;
  localparam logic [DATA_W-1:0] DETM_RESET = 16'h0000;
  localparam int DETM_EN_BIT = 15;
  localparam int DETM_LH_BIT = 14;
  localparam int DETM_SEL_LSB = 10;
  localparam int DETM_SEL_MSB = 13;
  localparam int DETM_REF_LSB = 0;
  localparam int DETM_REF_MSB = 9;

  // ---------------------------------------------------------------
  // interrupt registers
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 32'hfffff280;
  localparam logic [ADDR_W-1:0] IRQ_CLR_ADDR = 32'hfffff282;
  localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 32'hfffff284;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam int IRQ_DONE0_BIT = 0;
  localparam int IRQ_DONE1_BIT = 1;
  localparam int IRQ_DET0_BIT = 2;
  localparam int IRQ_DET1_BIT = 3;

endpackage

// [design/ards_result_mem.sv]
// result storage: one word per channel, two write ports, registered read
`timescale 1ns/1ps
module ards_result_mem
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // write ports, one per converter
  input wire logic wr_a,
  input wire logic [ards_pkg::IDX_W-1:0] wr_a_idx,
  input wire logic [ards_pkg::VAL_W-1:0] wr_a_val,
  input wire logic wr_b,
  input wire logic [ards_pkg::IDX_W-1:0] wr_b_idx,
  input wire logic [ards_pkg::VAL_W-1:0] wr_b_val,
  // read port
  input wire logic rd,
  input wire logic [ards_pkg::IDX_W-1:0] rd_idx,
  output logic [ards_pkg::VAL_W-1:0] rd_val
);

  logic [ards_pkg::VAL_W-1:0] word [0:ards_pkg::MEM_DEPTH-1];
  logic [ards_pkg::VAL_W-1:0] next_rd_val;

  // ---------------------------------------------------------------
  // storage entries
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ards_pkg::MEM_DEPTH; i++)
    begin : g_word
      logic [ards_pkg::VAL_W-1:0] next_word;
      always_comb
      begin
        next_word = word[i];
        if (wr_a && wr_a_idx == ards_pkg::IDX_W'(i))
        begin
          next_word = wr_a_val;
        end
        if (wr_b && wr_b_idx == ards_pkg::IDX_W'(i))
        begin
          next_word = wr_b_val;
        end
      end
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          word[i] <= ards_pkg::RES_RESET[ards_pkg::VAL_W-1:0];
        end
        else
        begin
          word[i] <= next_word;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rd_val = rd ? word[rd_idx] : rd_val;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_val <= '0;
    end
    else
    begin
      rd_val <= next_rd_val;
    end
  end

endmodule

// [design/ards_top.sv]
// converter result registers, voltage detect select and interrupt logic
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ards_top
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ards_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ards_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ards_pkg::DATA_W-1:0] reg_rdata,
  // converter 0 engine
  input wire logic conv0_done,
  input wire logic [ards_pkg::CH_W-1:0] conv0_chan,
  input wire logic [ards_pkg::VAL_W-1:0] conv0_value,
  input wire logic conv0_busy,
  output logic conv0_abort,
  // converter 1 engine
  input wire logic conv1_done,
  input wire logic [ards_pkg::CH_W-1:0] conv1_chan,
  input wire logic [ards_pkg::VAL_W-1:0] conv1_value,
  input wire logic conv1_busy,
  output logic conv1_abort,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [ards_pkg::DATA_W-1:0] detm0;
  logic [ards_pkg::DATA_W-1:0] detm1;
  logic [ards_pkg::DATA_W-1:0] next_detm0;
  logic [ards_pkg::DATA_W-1:0] next_detm1;
  logic [ards_pkg::IRQ_W-1:0] irq_stat;
  logic [ards_pkg::IRQ_W-1:0] irq_en;
  logic [ards_pkg::IRQ_W-1:0] next_irq_stat;
  logic [ards_pkg::IRQ_W-1:0] next_irq_en;
  logic [ards_pkg::IRQ_W-1:0] irq_set;
  logic [ards_pkg::IRQ_W-1:0] irq_clr;
  logic next_conv0_abort;
  logic next_conv1_abort;
  logic next_irq;
  logic res_hit;
  logic [ards_pkg::IDX_W-1:0] res_idx;
  logic [ards_pkg::RES_NUM-1:0] res_match;
  logic rd_res;
  logic next_rd_res;
  logic [ards_pkg::DATA_W-1:0] rd_reg;
  logic [ards_pkg::DATA_W-1:0] next_rd_reg;
  logic [ards_pkg::VAL_W-1:0] mem_val;
  logic wr0_ok;
  logic wr1_ok;
  logic [ards_pkg::IDX_W-1:0] wr0_idx;
  logic [ards_pkg::IDX_W-1:0] wr1_idx;
  logic det0_hit;
  logic det1_hit;

  // ---------------------------------------------------------------
  // result address decode
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ards_pkg::RES_NUM; g++)
    begin : g_dec
      assign res_match[g] = (reg_addr == ards_pkg::RES_ADDR[g]);
    end
  endgenerate

  always_comb
  begin
    res_hit = 1'b0;
    res_idx = '0;
    for (int k = 0; k < ards_pkg::RES_NUM; k++)
    begin
      if (res_match[k])
      begin
        res_hit = 1'b1;
        res_idx = ards_pkg::RES_SLOT[k];
      end
    end
  end

  // ---------------------------------------------------------------
  // result write steering
  // ---------------------------------------------------------------
  // converter 0 has no channel 6 or 7; such a report is dropped
  always_comb
  begin
    wr0_ok = conv0_done && (int'(conv0_chan) < ards_pkg::CONV0_CH);
    wr0_idx = {1'b0, conv0_chan};
    wr1_ok = conv1_done;
    wr1_idx = {1'b1, conv1_chan};
  end

  ards_result_mem u_mem
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_a(wr0_ok),
    .wr_a_idx(wr0_idx),
    .wr_a_val(conv0_value),
    .wr_b(wr1_ok),
    .wr_b_idx(wr1_idx),
    .wr_b_val(conv1_value),
    .rd(reg_rd && res_hit),
    .rd_idx(res_idx),
    .rd_val(mem_val)
  );

  // ---------------------------------------------------------------
  // detect mode registers
  // ---------------------------------------------------------------
  // writes to result offsets fall through every case here
  always_comb
  begin
    next_detm0 = detm0;
    next_detm1 = detm1;
    next_conv0_abort = 1'b0;
    next_conv1_abort = 1'b0;
    if (reg_wr && reg_addr == ards_pkg::DETM0_ADDR)
    begin
      next_detm0 = reg_wdata;
      next_conv0_abort = conv0_busy;
    end
    if (reg_wr && reg_addr == ards_pkg::DETM1_ADDR)
    begin
      next_detm1 = reg_wdata;
      next_conv1_abort = conv1_busy;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      detm0 <= ards_pkg::DETM_RESET;
      detm1 <= ards_pkg::DETM_RESET;
      conv0_abort <= 1'b0;
      conv1_abort <= 1'b0;
    end
    else
    begin
      detm0 <= next_detm0;
      detm1 <= next_detm1;
      conv0_abort <= next_conv0_abort;
      conv1_abort <= next_conv1_abort;
    end
  end

  // ---------------------------------------------------------------
  // voltage detect compare
  // ---------------------------------------------------------------
  function automatic logic det_check
  (
    input logic [ards_pkg::DATA_W-1:0] mode,
    input logic done,
    input logic [ards_pkg::CH_W-1:0] chan,
    input logic [ards_pkg::VAL_W-1:0] value
  );
    logic [ards_pkg::IDX_W-1:0] sel;
    logic [ards_pkg::VAL_W-1:0] ref_val;
    logic cmp;
    sel = mode[ards_pkg::DETM_SEL_MSB:ards_pkg::DETM_SEL_LSB];
    ref_val = mode[ards_pkg::DETM_REF_MSB:ards_pkg::DETM_REF_LSB];
    // lh low: reference above input; lh high: reference below input
    cmp = mode[ards_pkg::DETM_LH_BIT] ? (ref_val < value) : (ref_val > value);
    // prohibited select codes never match
    det_check = mode[ards_pkg::DETM_EN_BIT] && done
      && !sel[ards_pkg::IDX_W-1]
      && (sel[ards_pkg::CH_W-1:0] == chan) && cmp;
  endfunction

  always_comb
  begin
    det0_hit = det_check(detm0, wr0_ok, conv0_chan, conv0_value);
    det1_hit = det_check(detm1, wr1_ok, conv1_chan, conv1_value);
  end

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  always_comb
  begin
    irq_set = '0;
    irq_set[ards_pkg::IRQ_DONE0_BIT] = wr0_ok;
    irq_set[ards_pkg::IRQ_DONE1_BIT] = wr1_ok;
    irq_set[ards_pkg::IRQ_DET0_BIT] = det0_hit;
    irq_set[ards_pkg::IRQ_DET1_BIT] = det1_hit;
    irq_clr = '0;
    if (reg_wr && reg_addr == ards_pkg::IRQ_CLR_ADDR)
    begin
      irq_clr = reg_wdata[ards_pkg::IRQ_W-1:0];
    end
    // a new event in the clearing cycle survives
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    next_irq_en = irq_en;
    if (reg_wr && reg_addr == ards_pkg::IRQ_EN_ADDR)
    begin
      next_irq_en = reg_wdata[ards_pkg::IRQ_W-1:0];
    end
    next_irq = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_stat <= ards_pkg::IRQ_RESET;
      irq_en <= ards_pkg::IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rd_res = 1'b0;
    next_rd_reg = '0;
    if (reg_rd)
    begin
      if (res_hit)
      begin
        next_rd_res = 1'b1;
      end
      else if (reg_addr == ards_pkg::DETM0_ADDR)
      begin
        next_rd_reg = detm0;
      end
      else if (reg_addr == ards_pkg::DETM1_ADDR)
      begin
        next_rd_reg = detm1;
      end
      else if (reg_addr == ards_pkg::IRQ_STAT_ADDR)
      begin
        next_rd_reg = {{(ards_pkg::DATA_W-ards_pkg::IRQ_W){1'b0}}, irq_stat};
      end
      else if (reg_addr == ards_pkg::IRQ_EN_ADDR)
      begin
        next_rd_reg = {{(ards_pkg::DATA_W-ards_pkg::IRQ_W){1'b0}}, irq_en};
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_res <= 1'b0;
      rd_reg <= '0;
    end
    else
    begin
      rd_res <= next_rd_res;
      rd_reg <= next_rd_reg;
    end
  end

  // upper six bits of a result always read zero
  always_comb
  begin
    if (rd_res)
    begin
      reg_rdata = {{(ards_pkg::DATA_W-ards_pkg::VAL_W){1'b0}}, mem_val};
    end
    else
    begin
      reg_rdata = rd_reg;
    end
  end

endmodule

// [dv/ards_top_sva.sv]
// port-level assertions for the result and detect select block
`timescale 1ns/1ps
module ards_top_sva
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // converter ports
  input wire logic conv0_done,
  input wire logic [2:0] conv0_chan,
  input wire logic [9:0] conv0_value,
  input wire logic conv0_busy,
  input wire logic conv0_abort,
  input wire logic conv1_done,
  input wire logic [2:0] conv1_chan,
  input wire logic [9:0] conv1_value,
  input wire logic conv1_busy,
  input wire logic conv1_abort,
  // interrupt
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // done on converter 1, a quiet cycle, then a read of that channel's word
  sequence s_store1;
    conv1_done ##1 !conv1_done ##1 (reg_rd && !conv1_done &&
      reg_addr == 32'h0ffff250 + {28'h0, $past(conv1_chan, 2), 1'b0});
  endsequence
  sequence s_mode0_busy;
    reg_wr && reg_addr == 32'hfffff204 && conv0_busy;
  endsequence
  sequence s_mode1_busy;
    reg_wr && reg_addr == 32'hfffff244 && conv1_busy;
  endsequence

  chk_store_read: assert property (s_store1
    |=> reg_rdata == {6'h0, $past(conv1_value, 3)})
    else $error("result word differs from stored value");
  chk_upper_zero: assert property (reg_rd && reg_addr[7:4] inside {4'h1, 4'h5}
    |=> reg_rdata[15:10] == 6'h0)
    else $error("result upper bits not zero");
  chk_quiet_bus: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data without a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 32'hfffff300
    |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  chk_abort0_set: assert property (s_mode0_busy |=> conv0_abort)
    else $error("no abort after mode write while busy");
  chk_abort0_why: assert property (conv0_abort
    |-> $past(reg_wr && reg_addr == 32'hfffff204 && conv0_busy))
    else $error("abort without cause");
  chk_abort1_set: assert property (s_mode1_busy |=> conv1_abort)
    else $error("no abort on converter 1");
  chk_irq_cause: assert property ($rose(irq) |-> $past(conv0_done || conv1_done || reg_wr))
    else $error("interrupt rose without an event");
endmodule

bind ards_top ards_top_sva chk_u (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .conv0_done, .conv0_chan, .conv0_value, .conv0_busy, .conv0_abort,
  .conv1_done, .conv1_chan, .conv1_value, .conv1_busy, .conv1_abort, .irq);

// [dv/ards_eng_model.sv]
// conversion engine model driving one converter port
`timescale 1ns/1ps
module ards_eng_model
(
  // clock
  input wire logic ref_clk,
  // engine side
  input wire logic abort,
  output logic done,
  output logic [2:0] chan,
  output logic [9:0] value,
  output logic busy
);
  initial
  begin
    done = 1'b0;
    chan = 3'h0;
    value = 10'h0;
    busy = 1'b0;
  end
  // a mode write mid-conversion ends it without a result
  always @(posedge ref_clk)
    if (abort && busy)
      busy <= 1'b0;
  task automatic start();
    @(posedge ref_clk);
    busy <= 1'b1;
  endtask
  task automatic convert(input logic [2:0] c, input logic [9:0] v);
    start();
    @(posedge ref_clk);
    done <= 1'b1;
    chan <= c;
    value <= v;
    busy <= 1'b0;
    @(posedge ref_clk);
    done <= 1'b0;
    // stale lines do not keep the last value
    chan <= ~c;
    value <= ~v;
  endtask
endmodule

// [dv/ards_top_test.sv]
// self-checking bench for the result and detect select block
`timescale 1ns/1ps
module ards_top_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, got, m;
  logic irq, a0, a1, d0, d1, b0, b1, lh, e;
  logic [2:0] ch0, ch1, c;
  logic [3:0] sel;
  logic [9:0] v0, v1, v, w, rv;
  logic [9:0] exp_v [0:13];
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;

  initial forever #12.5 ref_clk = ~ref_clk;
  ards_top dut_u (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv0_done(d0), .conv0_chan(ch0), .conv0_value(v0), .conv0_busy(b0), .conv0_abort(a0),
    .conv1_done(d1), .conv1_chan(ch1), .conv1_value(v1), .conv1_busy(b1), .conv1_abort(a1),
    .irq);
  ards_eng_model eng0 (.ref_clk, .abort(a0), .done(d0), .chan(ch0), .value(v0), .busy(b0));
  ards_eng_model eng1 (.ref_clk, .abort(a1), .done(d1), .chan(ch1), .value(v1), .busy(b1));

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(n, x, reg_rdata);
  endtask
  // detect fires only on the selected channel and strict comparison
  function automatic logic fire(logic l, logic [3:0] s, logic [2:0] k, logic [9:0] r, x);
    return !s[3] && s[2:0] == k && (l ? r < x : r > x);
  endfunction
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(32'h045826ce));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      exp_v[i] = 10'h0;
      rchk("result reset", ards_pkg::RES_ADDR[i], 16'h0);
    end
    rchk("status reset", ards_pkg::IRQ_STAT_ADDR, 16'h0);
    rchk("unmapped", 32'hfffff300, 16'h0);
    $display("test reset done");
    // both converters finish together; result writes must be ignored
    repeat (30)
    begin
      c = 3'($urandom_range(5));
      sel = 4'($urandom_range(7));
      v = 10'($urandom);
      w = 10'($urandom);
      fork
        eng0.convert(c, v);
        eng1.convert(sel[2:0], w);
      join
      exp_v[c] = v;
      exp_v[6 + sel] = w;
      rchk("conv1 result", ards_pkg::RES_ADDR[6 + sel], {6'h0, w});
      wr(ards_pkg::RES_ADDR[c], 16'($urandom));
      rchk("conv0 result", ards_pkg::RES_ADDR[c], {6'h0, v});
    end
    wr(ards_pkg::IRQ_CLR_ADDR, 16'h000f);
    eng0.convert(3'h6 + 3'($urandom_range(1)), 10'h3ff);
    rchk("dropped status", ards_pkg::IRQ_STAT_ADDR, 16'h0);
    for (int i = 0; i < 14; i++)
      rchk("result hold", ards_pkg::RES_ADDR[i], {6'h0, exp_v[i]});
    $display("test results done");
    // masked and enabled interrupt
    wr(ards_pkg::IRQ_CLR_ADDR, 16'h000f);
    wr(ards_pkg::IRQ_EN_ADDR, 16'h0002);
    eng0.convert(3'h0, 10'h1);
    #1 chk("irq masked", 16'h0, 16'(irq));
    eng1.convert(3'h1, 10'h2);
    #1 chk("irq raised", 16'h1, 16'(irq));
    rchk("status", ards_pkg::IRQ_STAT_ADDR, 16'h0003);
    wr(ards_pkg::IRQ_CLR_ADDR, 16'h0002);
    chk("irq cleared", 16'h0, 16'(irq));
    $display("test interrupt done");
    // voltage detect on converter 1, including equal and prohibited codes
    wr(ards_pkg::IRQ_EN_ADDR, 16'h0008);
    for (int n = 0; n < 24; n++)
    begin
      rv = 10'($urandom);
      v = (n < 3) ? rv : 10'($urandom);
      lh = 1'($urandom);
      sel = (n % 5 == 4) ? 4'h8 | 4'($urandom) : 4'($urandom_range(7));
      c = (n % 4 == 3) ? 3'($urandom) : sel[2:0];
      m = {1'b1, lh, sel, rv};
      wr(ards_pkg::DETM1_ADDR, m);
      chk("abort1 idle", 16'h0, 16'(a1));
      rchk("mode1", ards_pkg::DETM1_ADDR, m);
      wr(ards_pkg::IRQ_CLR_ADDR, 16'h000f);
      eng1.convert(c, v);
      e = fire(lh, sel, c, rv, v);
      #1 chk("detect irq", 16'(e), 16'(irq));
      rchk("detect status", ards_pkg::IRQ_STAT_ADDR, {12'h0, e, 3'b010});
    end
    $display("test detect done");
    // mode write while converting ends the conversion
    eng0.start();
    wr(ards_pkg::DETM0_ADDR, 16'h8123);
    chk("abort0", 16'h1, 16'(a0));
    @(posedge ref_clk);
    #1 chk("abort0 end", 16'h0, 16'(a0));
    rchk("mode0", ards_pkg::DETM0_ADDR, 16'h8123);
    eng1.start();
    wr(ards_pkg::DETM1_ADDR, 16'h0000);
    chk("abort1", 16'h1, 16'(a1));
    @(posedge ref_clk);
    #1 chk("abort1 end", 16'h0, 16'(a1));
    rchk("mode1 abort", ards_pkg::DETM1_ADDR, 16'h0000);
    $display("test abort done");
    end_sim();
  end
endmodule
